// file: design/wdl_lock_bank.sv
// Register bank for memory correction status and the watchdog pin-disable lock.
//
// Notes on behaviour
// - Double-error flag, status bit 1, shows an uncorrected two-bit memory error.
// - Single-error flag, status bit 0, shows a corrected one-bit memory error.
// - Writing 0x87, 0x65, 0x1B as three separate writes opens the lock.
// - Any other code write, or global lock written one, closes the lock.
// - Reading the unlock code register always returns zero.
// - A completed sequence is ignored while the global watchdog lock is one.
// - Lock status is read-only control bit 1, resets to one, blocks register writes to permission.
// - Permission bit lets the external disable pin turn the watchdog off.
// - Writing permission one needs global lock and lock status both zero.
// - Permission bit takes its start-up value from the one-time memory.
`include "wdl_map.svh"

module wdl_lock_bank (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    // Register port from the serial control interface
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [`WDL_ADDR_W-1:0] reg_addr,
    input  wire logic [`WDL_DATA_W-1:0] reg_wdata,
    output logic      [`WDL_DATA_W-1:0] reg_rdata,
    output logic                        reg_rvalid,
    // Start-up load from the one-time-programmable memory
    input  wire logic                   otp_load,
    input  wire logic                   otp_permission,
    input  wire logic                   otp_single_err,
    input  wire logic                   otp_double_err,
    // Global watchdog lock, held in another register
    input  wire logic                   global_watchdog_lock,
    input  wire logic                   global_lock_set,
    // Watchdog disable path
    input  wire logic                   external_disable_pin,
    output logic                        watchdog_disable,
    // State seen by the rest of the device
    output logic                        pin_disable_permission,
    output logic                        permission_lock_status,
    output logic                        single_error_flag,
    output logic                        double_error_flag
);

    wdl_seq_if seq ();

    // Reset word of the status register, so each flag takes its own bit of it.
    localparam logic [`WDL_DATA_W-1:0] status_rst_val = `WDL_RST_CORR_STATUS;

    logic                              single_err_r;
    logic                              double_err_r;
    logic                              lock_r;
    logic                              permission_r;
    logic [`WDL_RSVD_MSB:`WDL_RSVD_LSB] rsvd_r;
    logic [`WDL_DATA_W-1:0]            rdata_r;
    logic                              rvalid_r;
    logic                              wd_disable_r;

    logic                              code_wr;
    logic                              ctrl_wr;
    logic                              unlock_ok;
    logic                              lock_nxt;
    logic                              permission_nxt;
    logic [`WDL_DATA_W-1:0]            rdata_nxt;
    logic [`WDL_DATA_W-1:0]            status_word;
    logic [`WDL_DATA_W-1:0]            control_word;

    // Address decode.
    assign code_wr = reg_wr && (reg_addr == `WDL_OFS_UNLOCK_CODE);
    assign ctrl_wr = reg_wr && (reg_addr == `WDL_OFS_DIS_CONTROL);

    // Hand code writes to the sequence tracker.
    assign seq.code_wr   = code_wr;
    assign seq.code_byte = reg_wdata;

    wdl_unlock_seq u_seq (
        .clock   (clock),
        .sys_rst (sys_rst),
        .seq     (seq)
    );

    // Unlock counts only if the global lock is clear and is not being set now.
    assign unlock_ok = seq.seq_complete
                       && !global_watchdog_lock
                       && !global_lock_set;

    // Lock status next value.
    always_comb begin
        lock_nxt = lock_r;
        if (code_wr) begin
            lock_nxt = !unlock_ok;
        end
        if (global_lock_set) begin
            lock_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lock_r <= `WDL_RST_LOCK;
        end else begin
            lock_r <= lock_nxt;
        end
    end

    // Permission bit next value. The lock is tested as it stood before this
    // cycle, so a write landing with the unlock byte still sees the lock.
    always_comb begin
        permission_nxt = permission_r;
        if (otp_load) begin
            permission_nxt = otp_permission;
        end else if (ctrl_wr && !lock_r) begin
            if (reg_wdata[`WDL_BIT_PERMISSION]) begin
                if (!global_watchdog_lock) begin
                    permission_nxt = 1'b1;
                end
            end else begin
                permission_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            permission_r <= `WDL_RST_PERMISSION;
        end else begin
            permission_r <= permission_nxt;
        end
    end

    // Reserved control bits are plain storage, writable at any time.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rsvd_r <= '0;
        end else if (ctrl_wr) begin
            rsvd_r <= reg_wdata[`WDL_RSVD_MSB:`WDL_RSVD_LSB];
        end
    end

    // Correction status mirrors the latest memory check; a clean check
    // clears a flag left by an earlier one.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            single_err_r <= status_rst_val[`WDL_BIT_SINGLE_ERR];
            double_err_r <= status_rst_val[`WDL_BIT_DOUBLE_ERR];
        end else if (otp_load) begin
            single_err_r <= otp_single_err;
            double_err_r <= otp_double_err;
        end
    end

    // Read words.
    always_comb begin
        status_word                      = '0;
        status_word[`WDL_BIT_SINGLE_ERR] = single_err_r;
        status_word[`WDL_BIT_DOUBLE_ERR] = double_err_r;
    end

    always_comb begin
        control_word                                 = '0;
        control_word[`WDL_RSVD_MSB:`WDL_RSVD_LSB]    = rsvd_r;
        control_word[`WDL_BIT_LOCK_STATUS]           = lock_r;
        control_word[`WDL_BIT_PERMISSION]            = permission_r;
    end

    always_comb begin
        case (reg_addr)
            `WDL_OFS_CORR_STATUS: begin
                rdata_nxt = status_word;
            end
            `WDL_OFS_UNLOCK_CODE: begin
                rdata_nxt = `WDL_READ_ZERO;
            end
            `WDL_OFS_DIS_CONTROL: begin
                rdata_nxt = control_word;
            end
            default: begin
                rdata_nxt = `WDL_READ_ZERO;
            end
        endcase
    end

    // Read data is registered; it holds until the next read.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else if (reg_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd;
        end
    end

    // Pin gate. The pin is taken as already synchronous; one register stage
    // keeps the output glitch free at the cost of one cycle of latency.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wd_disable_r <= 1'b0;
        end else begin
            wd_disable_r <= external_disable_pin && permission_r;
        end
    end

    assign reg_rdata              = rdata_r;
    assign reg_rvalid             = rvalid_r;
    assign watchdog_disable       = wd_disable_r;
    assign pin_disable_permission = permission_r;
    assign permission_lock_status = lock_r;
    assign single_error_flag      = single_err_r;
    assign double_error_flag      = double_err_r;

endmodule

// file: shared/wdl_map.svh
// Register offsets, field positions, reset values and unlock codes of the lock block.
`ifndef WDL_MAP_SVH
`define WDL_MAP_SVH

`define WDL_ADDR_W              8
`define WDL_DATA_W              8

`define WDL_OFS_CORR_STATUS     8'h33
`define WDL_OFS_UNLOCK_CODE     8'h34
`define WDL_OFS_DIS_CONTROL     8'h35

`define WDL_BIT_SINGLE_ERR      0
`define WDL_BIT_DOUBLE_ERR      1
`define WDL_BIT_PERMISSION      0
`define WDL_BIT_LOCK_STATUS     1
`define WDL_RSVD_LSB            2
`define WDL_RSVD_MSB            7

`define WDL_RST_CORR_STATUS     8'h00
`define WDL_RST_CONTROL         8'h00
`define WDL_RST_LOCK            1'b1
`define WDL_RST_PERMISSION      1'b0
`define WDL_READ_ZERO           8'h00

`define WDL_CODE_FIRST          8'h87
`define WDL_CODE_SECOND         8'h65
`define WDL_CODE_THIRD          8'h1B

`endif

// file: shared/wdl_pkg.sv
// Types shared by the lock block modules.
package wdl_pkg;

    typedef logic [7:0] wdl_byte_t;

    typedef enum logic [1:0] {
        WDL_SEQ_IDLE,
        WDL_SEQ_GOT_FIRST,
        WDL_SEQ_GOT_SECOND
    } wdl_seq_state_t;

endpackage

// file: shared/wdl_seq_if.sv
// Carrier between the register bank and the unlock sequence tracker.
interface wdl_seq_if;

    logic              code_wr;
    wdl_pkg::wdl_byte_t code_byte;
    logic              seq_complete;

    modport bank (
        output code_wr,
        output code_byte,
        input  seq_complete
    );

    modport tracker (
        input  code_wr,
        input  code_byte,
        output seq_complete
    );

endinterface

// file: design/wdl_unlock_seq.sv
// Tracker of the three-byte unlock sequence written to the unlock code register.
`include "wdl_map.svh"

module wdl_unlock_seq (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Link to the register bank
    wdl_seq_if.tracker seq
);

    wdl_pkg::wdl_seq_state_t state_r;
    wdl_pkg::wdl_seq_state_t state_nxt;
    logic                    complete_nxt;

    // A byte that breaks the sequence is still checked as a fresh first byte,
    // so a retry does not cost the host an extra write.
    always_comb begin
        state_nxt    = state_r;
        complete_nxt = 1'b0;
        if (seq.code_wr) begin
            case (state_r)
                wdl_pkg::WDL_SEQ_IDLE: begin
                    if (seq.code_byte == `WDL_CODE_FIRST) begin
                        state_nxt = wdl_pkg::WDL_SEQ_GOT_FIRST;
                    end
                end
                wdl_pkg::WDL_SEQ_GOT_FIRST: begin
                    if (seq.code_byte == `WDL_CODE_SECOND) begin
                        state_nxt = wdl_pkg::WDL_SEQ_GOT_SECOND;
                    end else if (seq.code_byte == `WDL_CODE_FIRST) begin
                        state_nxt = wdl_pkg::WDL_SEQ_GOT_FIRST;
                    end else begin
                        state_nxt = wdl_pkg::WDL_SEQ_IDLE;
                    end
                end
                wdl_pkg::WDL_SEQ_GOT_SECOND: begin
                    if (seq.code_byte == `WDL_CODE_THIRD) begin
                        complete_nxt = 1'b1;
                        state_nxt    = wdl_pkg::WDL_SEQ_IDLE;
                    end else if (seq.code_byte == `WDL_CODE_FIRST) begin
                        state_nxt = wdl_pkg::WDL_SEQ_GOT_FIRST;
                    end else begin
                        state_nxt = wdl_pkg::WDL_SEQ_IDLE;
                    end
                end
                default: begin
                    state_nxt = wdl_pkg::WDL_SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= wdl_pkg::WDL_SEQ_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Completion is combinational so the bank resolves the lock in the same
    // cycle as the write that finishes the sequence.
    assign seq.seq_complete = complete_nxt;

endmodule

// file: tb/wdl_lock_bank_props.sv
// Concurrent checks on the ports of the lock register bank.
module wdl_lock_bank_props (
    // Clock and reset
    input logic       clock,
    input logic       sys_rst,
    // Register port
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    input logic       reg_rvalid,
    // Memory load, global lock and pin
    input logic       otp_load,
    input logic       otp_permission,
    input logic       otp_single_err,
    input logic       otp_double_err,
    input logic       global_watchdog_lock,
    input logic       global_lock_set,
    input logic       external_disable_pin,
    // State outputs
    input logic       watchdog_disable,
    input logic       pin_disable_permission,
    input logic       permission_lock_status,
    input logic       single_error_flag,
    input logic       double_error_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic cw;
    assign cw = reg_wr && reg_addr == 8'h34;
    property p_double_err; otp_load |=> double_error_flag == $past(otp_double_err); endproperty
    a_double_err: assert property (p_double_err) else $error("double flag wrong");
    property p_single_err; otp_load |=> single_error_flag == $past(otp_single_err); endproperty
    a_single_err: assert property (p_single_err) else $error("single flag wrong");
    property p_open;
        cw && reg_wdata == 8'h87 ##1 cw && reg_wdata == 8'h65 ##1 cw && reg_wdata == 8'h1B
        && !global_watchdog_lock && !global_lock_set |=> !permission_lock_status;
    endproperty
    a_open: assert property (p_open) else $error("lock did not open");
    property p_close; (cw && reg_wdata != 8'h1B) || global_lock_set |=> permission_lock_status;
    endproperty
    a_close: assert property (p_close) else $error("lock did not close");
    property p_rd0; reg_rd && reg_addr == 8'h34 |=> reg_rvalid && reg_rdata == 8'h00; endproperty
    a_rd0: assert property (p_rd0) else $error("code read not zero");
    property p_glock; permission_lock_status && global_watchdog_lock |=> permission_lock_status;
    endproperty
    a_glock: assert property (p_glock) else $error("lock opened under global lock");
    property p_frozen; permission_lock_status && !otp_load |=> $stable(pin_disable_permission);
    endproperty
    a_frozen: assert property (p_frozen) else $error("permission changed while locked");
    property p_wd;
        1'b1 |=> watchdog_disable == ($past(external_disable_pin) && $past(pin_disable_permission));
    endproperty
    a_wd: assert property (p_wd) else $error("disable output wrong");
    property p_rise;
        $rose(pin_disable_permission) && !$past(otp_load) |-> $past(reg_wr && reg_addr == 8'h35
        && reg_wdata[0] && !global_watchdog_lock && !permission_lock_status);
    endproperty
    a_rise: assert property (p_rise) else $error("permission set without right");
    property p_load; otp_load |=> pin_disable_permission == $past(otp_permission); endproperty
    a_load: assert property (p_load) else $error("permission not loaded");
    c_open: cover property (!permission_lock_status);
    c_rise: cover property ($rose(pin_disable_permission));
    c_read: cover property (reg_rvalid);
endmodule

// file: tb/wdl_host_model.sv
// Register-port host standing in for the serial control engine.
module wdl_host_model (
    // Clock
    input  logic       clock,
    // Register port
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input  logic [7:0] reg_rdata,
    input  logic       reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // The strobe stays up after a write so that writes can go back to back.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
    endtask
    // Released lines show the inverse so stale values never look valid.
    task automatic idle();
        @(negedge clock);
        reg_wr = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clock);
        reg_wr = 1'b0;
        reg_addr = a;
        reg_rd = 1'b1;
        // The valid pulse stands for the one cycle after the strobe edge only.
        @(negedge clock);
        d = reg_rdata;
        v = reg_rvalid;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
endmodule

// file: tb/test_wdl_lock_bank.sv
// Self-checking bench for the lock register bank.
module test_wdl_lock_bank;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock = 1'b0, sys_rst = 1'b1, reg_wr, reg_rd, reg_rvalid, vv;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic       otp_load = 1'b0, otp_permission = 1'b0, otp_single_err = 1'b0;
    logic       otp_double_err = 1'b0, global_watchdog_lock = 1'b0, global_lock_set = 1'b0;
    logic       external_disable_pin = 1'b0, watchdog_disable, pin_disable_permission;
    logic       permission_lock_status, single_error_flag, double_error_flag;
    int         fails = 0, n_checks = 0, cyc = 0;
    logic [7:0] state_out;
    assign state_out = {6'h00, permission_lock_status, pin_disable_permission};
    always #25 clock = ~clock;
    wdl_host_model i_host (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid);
    wdl_lock_bank i_dut (.clock, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid, .otp_load, .otp_permission, .otp_single_err,
        .otp_double_err, .global_watchdog_lock, .global_lock_set, .external_disable_pin,
        .watchdog_disable, .pin_disable_permission, .permission_lock_status,
        .single_error_flag, .double_error_flag);
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, rv, vv);
        chk("rvalid", 8'h01, {7'h00, vv});
        chk("rdata", e, rv);
        if (a == 8'h35) begin
            chk("state_out", e & 8'h03, state_out);
        end
    endtask
    function automatic logic [7:0] ctl(input logic p, input logic l);
        return {6'h00, l, p};
    endfunction
    task automatic unlock(input logic [7:0] b);
        i_host.wr(8'h34, 8'h87);
        i_host.wr(8'h34, 8'h65);
        i_host.wr(8'h34, b);
        i_host.idle();
    endtask
    task automatic otp(input logic p, input logic s, input logic d);
        @(negedge clock);
        otp_load = 1'b1;
        otp_permission = p;
        otp_single_err = s;
        otp_double_err = d;
        @(negedge clock);
        otp_load = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        logic p;
        void'($urandom(39));
        repeat (12) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        rchk(8'h35, ctl(1'b0, 1'b1));
        rchk(8'h33, 8'h00);
        rchk(8'h40, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            p = 1'($urandom);
            otp(p, i[0], i[1]);
            chk("single_flag", {7'h00, i[0]}, {7'h00, single_error_flag});
            chk("double_flag", {7'h00, i[1]}, {7'h00, double_error_flag});
            rchk(8'h33, {6'h00, i[1], i[0]});
            rchk(8'h35, ctl(p, 1'b1));
        end
        otp(1'b0, 1'b0, 1'b0);
        i_host.wr(8'h35, 8'h01);
        rchk(8'h35, ctl(1'b0, 1'b1));
        $display("test load done");
        unlock(8'h55);
        rchk(8'h35, ctl(1'b0, 1'b1));
        unlock(8'h1B);
        rchk(8'h35, ctl(1'b0, 1'b0));
        rchk(8'h34, 8'h00);
        global_watchdog_lock = 1'b1;
        i_host.wr(8'h35, 8'h01);
        rchk(8'h35, ctl(1'b0, 1'b0));
        global_watchdog_lock = 1'b0;
        i_host.wr(8'h35, 8'h01);
        rchk(8'h35, ctl(1'b1, 1'b0));
        for (int i = 0; i < 8; i++) begin
            @(negedge clock);
            external_disable_pin = 1'($urandom);
            @(negedge clock);
            chk("wd_disable", {7'h00, external_disable_pin}, {7'h00, watchdog_disable});
        end
        $display("test unlock done");
        global_lock_set = 1'b1;
        global_watchdog_lock = 1'b1;
        @(negedge clock);
        global_lock_set = 1'b0;
        rchk(8'h35, ctl(1'b1, 1'b1));
        unlock(8'h1B);
        rchk(8'h35, ctl(1'b1, 1'b1));
        global_watchdog_lock = 1'b0;
        unlock(8'h1B);
        i_host.wr(8'h35, 8'h00);
        rchk(8'h35, ctl(1'b0, 1'b0));
        external_disable_pin = 1'b1;
        @(negedge clock);
        chk("wd_disable_off", 8'h00, {7'h00, watchdog_disable});
        $display("test global lock done");
        for (int i = 0; i < 6; i++) begin
            unlock(8'h1B);
            i_host.wr(8'h34, 8'($urandom));
            i_host.idle();
            rchk(8'h35, ctl(1'b0, 1'b1));
            rchk(8'h34, 8'h00);
        end
        $display("test random codes done");
        // A repeated first byte must start the sequence afresh.
        i_host.wr(8'h34, 8'h87);
        unlock(8'h1B);
        rchk(8'h35, ctl(1'b0, 1'b0));
        $display("test restart done");
        tally_and_finish();
    end
endmodule
bind wdl_lock_bank wdl_lock_bank_props i_props (.clock, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .otp_load, .otp_permission, .otp_single_err,
    .otp_double_err, .global_watchdog_lock, .global_lock_set, .external_disable_pin,
    .watchdog_disable, .pin_disable_permission, .permission_lock_status,
    .single_error_flag, .double_error_flag);
